/* design/adc_oversample_average_filter.sv */
// Oversampling/averaging post-filter for one converter channel.
// Assumes an AXI4-Lite master and a converter core on the same clock.
//
// Contract
// - Filter runs only while enabled; off clears ready
// - Mode 11 averages, 00 oversamples, others reserved
// - Oversample code 111: 128 samples, 12.4
// - Oversample code 000: 4 samples, 12.1
// - Average codes: 2 samples up to 256
// - Interrupt only when interrupt enable set
// - Ready flag at control bit 8
// - Reading result register clears ready flag
`timescale 1ns/1ps
module adc_oversample_average_filter
  import filter_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite write address and data
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // Converter samples
  input  wire sample_type        sample,
  // Interrupt
  output logic                   irq
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  control_type         ctrl_r;
  logic                ready_r;
  logic                aw_held_r;
  logic [ADDR_W-1:0]   awaddr_r;
  logic                w_held_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                rvalid_r;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;
  logic                wr_go;
  logic                rd_go;
  logic                ctrl_wr;
  logic                status_wr;
  logic                mask_wr;
  logic                result_rd;
  logic                restart;
  logic                run;
  logic [3:0]          lg;
  logic [3:0]          shift;
  logic                acc_done;
  logic [RESULT_W-1:0] result;
  logic                status;
  logic                mask;
  logic                irq_raw;
  logic [15:0]         ctrl_word;
  control_type         ctrl_nxt;

  // ---------------------------------------------------------------
  // Bus handshakes
  // ---------------------------------------------------------------
  assign s_axi_awready = ce && !aw_held_r && !bvalid_r;
  assign s_axi_wready  = ce && !w_held_r && !bvalid_r;
  assign s_axi_arready = ce && !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  assign wr_go     = ce && aw_held_r && w_held_r && !bvalid_r;
  assign rd_go     = s_axi_arvalid && s_axi_arready;
  assign ctrl_wr   = wr_go && (awaddr_r == CTRL_OFF);
  assign status_wr = wr_go && (awaddr_r == STATUS_OFF) && wstrb_r[0];
  assign mask_wr   = wr_go && (awaddr_r == MASK_OFF) && wstrb_r[0];
  assign result_rd = rd_go && (s_axi_araddr == RESULT_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        case (awaddr_r)
          CTRL_OFF, RESULT_OFF, STATUS_OFF, MASK_OFF: bresp_r <= RESP_OKAY;
          default:                                   bresp_r <= RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  assign ctrl_word = {ctrl_r.on, ctrl_r.mode, ctrl_r.ratio, ctrl_r.irq_en,
                      ready_r, 8'h00};

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wstrb_r[1]) begin
      ctrl_nxt.on     = wdata_r[ON_BIT];
      ctrl_nxt.mode   = wdata_r[MODE_LSB +: 2];
      ctrl_nxt.ratio  = wdata_r[RATIO_LSB +: 3];
      ctrl_nxt.irq_en = wdata_r[IRQEN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= control_type'({CTRL_RESET[ON_BIT], CTRL_RESET[MODE_LSB +: 2],
                               CTRL_RESET[RATIO_LSB +: 3], CTRL_RESET[IRQEN_BIT]});
    end else if (ce && ctrl_wr) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // A new mode or ratio throws away the partial group
  assign restart = ctrl_wr && (ctrl_nxt != ctrl_r);
  assign run     = ctrl_r.on && mode_valid(ctrl_r.mode);
  assign lg      = ratio_log2(ctrl_r.mode, ctrl_r.ratio);
  assign shift   = result_shift(ctrl_r.mode, lg);

  // ---------------------------------------------------------------
  // Filter core
  // ---------------------------------------------------------------
  filter_accum u_accum (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .run      (run),
    .restart  (restart),
    .lg       (lg),
    .shift    (shift),
    .sample   (sample),
    .done_r   (acc_done),
    .result_r (result)
  );

  // Ready flag: off clears it; a new result beats a read of the old one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_r <= 1'b0;
    end else if (ce) begin
      if (!ctrl_r.on) begin
        ready_r <= 1'b0;
      end else if (acc_done) begin
        ready_r <= 1'b1;
      end else if (result_rd) begin
        ready_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------
  filter_event_irq u_irq (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .event_in  (acc_done && ctrl_r.irq_en),
    .status_wr (status_wr),
    .mask_wr   (mask_wr),
    .wdata0    (wdata_r[EVENT_BIT]),
    .status_r  (status),
    .mask_r    (mask),
    .irq       (irq_raw)
  );

  assign irq = irq_raw && ctrl_r.irq_en;

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rresp_r  <= RESP_OKAY;
        case (s_axi_araddr)
          CTRL_OFF:   rdata_r <= {16'h0000, ctrl_word};
          RESULT_OFF: rdata_r <= {16'h0000, result};
          STATUS_OFF: rdata_r <= {31'h0000_0000, status};
          MASK_OFF:   rdata_r <= {31'h0000_0000, mask};
          default: begin
            rdata_r <= '0;
            rresp_r <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] seen_r;
  logic             live_r;

  // Mirrors the accumulator: a sample counts only once it is running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      live_r <= 1'b0;
    end else if (ce) begin
      live_r <= run && !restart;
    end
  end

  // Counts samples taken into the current group
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_r <= '0;
    end else if (ce) begin
      if (!run || restart) begin
        seen_r <= '0;
      end else if (acc_done) begin
        seen_r <= CNT_W'(sample.valid && live_r);
      end else begin
        seen_r <= seen_r + CNT_W'(sample.valid && live_r);
      end
    end
  end

  off_clears_ready_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && !ctrl_r.on |=> !ready_r)
    else $error("ready stayed set while filter off");

  reserved_mode_idle_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && !mode_valid(ctrl_r.mode) ##1 ce && !mode_valid(ctrl_r.mode) |=> !acc_done)
    else $error("result produced in reserved mode");

  over128_group_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    acc_done && ctrl_r.mode == MODE_OVERSAMPLE && ctrl_r.ratio == 3'h7
    |-> seen_r == 9'h080)
    else $error("oversample code 7 group not 128 samples");

  over4_width_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    acc_done && ctrl_r.mode == MODE_OVERSAMPLE && ctrl_r.ratio == 3'h0
    |-> seen_r == 9'h004 && result < 16'h2000)
    else $error("oversample code 0 group wrong");

  avg_group_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    acc_done && ctrl_r.mode == MODE_AVERAGE
    |-> seen_r == (CNT_W'(2) << ctrl_r.ratio) && result < 16'h1000)
    else $error("average group size or width wrong");

  irq_gated_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    irq |-> ctrl_r.irq_en && status && mask)
    else $error("interrupt without enable");

  irq_raise_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && acc_done && ctrl_r.irq_en ##1 ctrl_r.irq_en && mask |-> irq)
    else $error("interrupt not raised on result");

  ready_readback_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_go && s_axi_araddr == CTRL_OFF |=> rdata_r[READY_BIT] == $past(ready_r))
    else $error("control read lost ready flag");

  read_clears_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    result_rd && !acc_done |=> !ready_r)
    else $error("result read did not clear ready");

  done_sets_ready_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && acc_done && ctrl_r.on |=> ready_r && seen_r <= 9'h001)
    else $error("group end did not set ready");

  result_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !acc_done |-> $stable(result))
    else $error("result changed without a finished group");

  ready_source_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(ready_r) |-> $past(acc_done))
    else $error("ready rose without a finished group");

endmodule

/* design/filter_pkg.sv */
// Constants, carriers and helpers of the oversampling/averaging post-filter.
// Assumes one 20 MHz clock shared by the bus, the converter core and the filter.
package filter_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int         ADDR_W     = 4;
  localparam logic [3:0] CTRL_OFF   = 4'h0;
  localparam logic [3:0] RESULT_OFF = 4'h4;
  localparam logic [3:0] STATUS_OFF = 4'h8;
  localparam logic [3:0] MASK_OFF   = 4'hc;

  // ---------------------------------------------------------------
  // Control register fields and reset values
  // ---------------------------------------------------------------
  localparam int          ON_BIT     = 15;
  localparam int          MODE_LSB   = 13;
  localparam int          RATIO_LSB  = 10;
  localparam int          IRQEN_BIT  = 9;
  localparam int          READY_BIT  = 8;
  localparam int          EVENT_BIT  = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [0:0]  MASK_RESET = 1'h0;

  localparam logic [1:0] MODE_OVERSAMPLE = 2'h0;
  localparam logic [1:0] MODE_AVERAGE    = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Data widths
  // ---------------------------------------------------------------
  localparam int SAMPLE_W = 12;
  localparam int ACC_W    = 20;
  localparam int RESULT_W = 16;
  localparam int CNT_W    = 9;

  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] data;
  } sample_type;

  typedef struct packed {
    logic       on;
    logic [1:0] mode;
    logic [2:0] ratio;
    logic       irq_en;
  } control_type;

  typedef enum logic {
    FS_IDLE = 1'b0,
    FS_RUN  = 1'b1
  } filt_state_type;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Log2 of the number of samples per group
  function automatic logic [3:0] ratio_log2(input logic [1:0] mode,
                                            input logic [2:0] ratio);
    if (mode == MODE_AVERAGE) begin
      return {1'b0, ratio} + 4'h1;
    end
    case (ratio)
      3'h0:    return 4'h2;
      3'h1:    return 4'h4;
      3'h2:    return 4'h6;
      3'h3:    return 4'h8;
      3'h4:    return 4'h1;
      3'h5:    return 4'h3;
      3'h6:    return 4'h5;
      default: return 4'h7;
    endcase
  endfunction

  // Right shift that turns the sum into the result format
  function automatic logic [3:0] result_shift(input logic [1:0] mode,
                                              input logic [3:0] lg);
    if (mode == MODE_AVERAGE) begin
      return lg;
    end
    return lg >> 1;
  endfunction

  function automatic logic mode_valid(input logic [1:0] mode);
    return (mode == MODE_AVERAGE) || (mode == MODE_OVERSAMPLE);
  endfunction

endpackage

/* design/filter_accum.sv */
// Sample accumulator: sums one group of samples and scales the sum.
// Assumes samples arrive on the same clock as one-cycle valid strobes.
`timescale 1ns/1ps
module filter_accum
  import filter_pkg::*;
(
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  // Control
  input  wire logic                run,
  input  wire logic                restart,
  input  wire logic [3:0]          lg,
  input  wire logic [3:0]          shift,
  // Samples and result
  input  wire sample_type          sample,
  output logic                     done_r,
  output logic [RESULT_W-1:0]      result_r
);

  filt_state_type    state_r;
  logic [ACC_W-1:0]  acc_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [ACC_W-1:0]  sum_nxt;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [ACC_W-1:0]  scaled;

  assign sum_nxt = acc_r + ACC_W'(sample.data);
  assign cnt_nxt = cnt_r + 9'h001;
  assign scaled  = sum_nxt >> shift;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r  <= FS_IDLE;
      acc_r    <= '0;
      cnt_r    <= '0;
      done_r   <= 1'b0;
      result_r <= '0;
    end else if (ce) begin
      done_r <= 1'b0;
      case (state_r)
        FS_IDLE: begin
          acc_r <= '0;
          cnt_r <= '0;
          if (run && !restart) begin
            state_r <= FS_RUN;
          end
        end
        FS_RUN: begin
          if (!run || restart) begin
            state_r <= FS_IDLE;
            acc_r   <= '0;
            cnt_r   <= '0;
          end else if (sample.valid) begin
            if (cnt_nxt == (CNT_W'(1) << lg)) begin
              result_r <= scaled[RESULT_W-1:0];
              done_r   <= 1'b1;
              acc_r    <= '0;
              cnt_r    <= '0;
            end else begin
              acc_r <= sum_nxt;
              cnt_r <= cnt_nxt;
            end
          end
        end
        default: state_r <= FS_IDLE;
      endcase
    end
  end

endmodule

/* design/filter_event_irq.sv */
// Sticky event status with mask, write-one-to-clear, one level interrupt.
// Assumes register writes come as one-cycle strobes on the same clock.
`timescale 1ns/1ps
module filter_event_irq
  import filter_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // Event and register access
  input  wire logic event_in,
  input  wire logic status_wr,
  input  wire logic mask_wr,
  input  wire logic wdata0,
  // State and interrupt
  output logic      status_r,
  output logic      mask_r,
  output logic      irq
);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= 1'b0;
    end else if (ce) begin
      if (event_in) begin
        status_r <= 1'b1;
      end else if (status_wr && wdata0) begin
        status_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= MASK_RESET;
    end else if (ce && mask_wr) begin
      mask_r <= wdata0;
    end
  end

  assign irq = status_r & mask_r;

endmodule

/* verification/sample_source.sv */
// Behavioural converter core: sends bursts of one-cycle sample strobes.
// Assumes the filter clock; start is a one-cycle request while idle.
`timescale 1ns/1ps
module sample_source
  import filter_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Burst request
  input  wire logic        start,
  input  wire logic        slow,
  input  wire logic [8:0]  count,
  input  wire logic [11:0] base,
  // Samples
  output sample_type       sample,
  output logic             busy
);
  logic [8:0] left_r;
  logic [1:0] gap_r;
  logic       odd_r;

  // Values alternate base and base+2; idle data is scrambled
  always_ff @(posedge aclk) begin
    sample.valid <= 1'b0;
    sample.data  <= ~sample.data;
    if (!aresetn) begin
      left_r      <= 9'h0;
      gap_r       <= 2'h0;
      odd_r       <= 1'b0;
      sample.data <= 12'h0;
    end else if (start) begin
      left_r <= count;
      gap_r  <= 2'h0;
      odd_r  <= 1'b0;
    end else if (left_r != 9'h0) begin
      if (gap_r == 2'h0) begin
        sample.valid <= 1'b1;
        sample.data  <= odd_r ? base + 12'h002 : base;
        odd_r        <= ~odd_r;
        left_r       <= left_r - 9'h1;
        gap_r        <= slow ? 2'h3 : 2'h1;
      end else begin
        gap_r <= gap_r - 2'h1;
      end
    end
  end

  assign busy = (left_r != 9'h0) || sample.valid;
endmodule

/* verification/adc_oversample_average_filter_tb.sv */
// Self-checking bench of the oversampling/averaging post-filter.
// Assumes the filter package and the behavioural converter core model.
`timescale 1ns/1ps
module adc_oversample_average_filter_tb
  import filter_pkg::*;
;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic              awv = 1'b0;
  logic              wv = 1'b0;
  logic              br = 1'b0;
  logic              arv = 1'b0;
  logic              rr = 1'b0;
  logic [ADDR_W-1:0] awa = '0;
  logic [ADDR_W-1:0] ara = '0;
  logic [31:0]       wd = '0;
  logic              awr;
  logic              wrdy;
  logic              bv;
  logic              arr;
  logic              rv;
  logic              irq;
  logic [1:0]        bresp;
  logic [1:0]        rresp;
  logic [31:0]       rdata;
  logic              go = 1'b0;
  logic              slow = 1'b0;
  logic [8:0]        cnt = 9'h0;
  logic              busy;
  sample_type        smp;
  int                n_mismatch = 0;
  int                num_checks = 0;
  int                cyc = 0;
  logic [1:0]        rsp;

  always #25 aclk = ~aclk;

  adc_oversample_average_filter DUT (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .sample(smp), .irq(irq)
  );

  sample_source core (
    .aclk(aclk), .aresetn(aresetn), .start(go), .slow(slow), .count(cnt),
    .base(12'hffd), .sample(smp), .busy(busy)
  );

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_irq(input logic e);
    @(negedge aclk);
    num_checks++;
    if (irq !== e) begin
      n_mismatch++;
      $display("mismatch irq expected %b seen %b", e, irq);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awv <= 1'b1;
    awa <= a;
    wv  <= 1'b1;
    wd  <= d;
    br  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    r = bresp;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string nm,
                       input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    arv <= 1'b1;
    ara <= a;
    rr  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    chk(nm, e, rdata);
    chk({nm, " resp"}, {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic feed(input logic [8:0] n);
    @(posedge aclk);
    go  <= 1'b1;
    cnt <= n;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (busy);
    repeat (4) @(posedge aclk);
  endtask

  function automatic logic [31:0] cv(input logic [1:0] m, input logic [2:0] q,
                                     input logic ie);
    return {16'h0, 1'b1, m, q, ie, 9'h0};
  endfunction

  task automatic grp(input logic [1:0] m, input logic [2:0] q, input logic ie,
                     input logic [8:0] n, input logic [15:0] e);
    wr(CTRL_OFF, cv(m, q, ie), rsp);
    repeat (3) @(posedge aclk);
    feed(n);
    rdchk(CTRL_OFF, cv(m, q, ie) | 32'h0000_0100, "ready set");
    rdchk(RESULT_OFF, {16'h0, e}, "result");
    rdchk(CTRL_OFF, cv(m, q, ie), "ready after read");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rdchk(CTRL_OFF, 32'h0, "control");
    rdchk(RESULT_OFF, 32'h0, "result");
    rdchk(STATUS_OFF, 32'h0, "status");
    rdchk(MASK_OFF, 32'h0, "mask");
    rdchk(4'h2, 32'h0, "unmapped", RESP_SLVERR);
    wr(4'h6, 32'h1, rsp);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rsp});
  endtask

  // Mean sample is 0xffe; oversampling keeps N*mean >> floor(log2 N / 2)
  task automatic t_oversample;
    int ns [8] = '{4, 16, 64, 256, 2, 8, 32, 128};
    int sh [8] = '{1, 2, 3, 4, 0, 1, 2, 3};
    for (int c = 0; c < 8; c++) begin
      grp(MODE_OVERSAMPLE, c[2:0], 1'b0, ns[c][8:0], 16'((ns[c] * 4094) >> sh[c]));
    end
  endtask

  task automatic t_average;
    for (int c = 0; c < 8; c++) begin
      grp(MODE_AVERAGE, c[2:0], 1'b0, 9'(2 << c), 16'h0ffe);
    end
  endtask

  task automatic t_restart;
    slow <= 1'b1;
    grp(MODE_OVERSAMPLE, 3'h0, 1'b0, 9'd4, 16'h1ffc);
    feed(9'd2);
    rdchk(CTRL_OFF, cv(MODE_OVERSAMPLE, 3'h0, 1'b0), "partial group");
    feed(9'd2);
    rdchk(CTRL_OFF, cv(MODE_OVERSAMPLE, 3'h0, 1'b0) | 32'h0000_0100, "next group");
    rdchk(RESULT_OFF, 32'h0000_1ffc, "next result");
    slow <= 1'b0;
  endtask

  task automatic t_irq;
    wr(MASK_OFF, 32'h1, rsp);
    grp(MODE_AVERAGE, 3'h0, 1'b1, 9'd2, 16'h0ffe);
    chk_irq(1'b1);
    rdchk(STATUS_OFF, 32'h1, "status");
    wr(MASK_OFF, 32'h0, rsp);
    chk_irq(1'b0);
    wr(MASK_OFF, 32'h1, rsp);
    chk_irq(1'b1);
    wr(STATUS_OFF, 32'h1, rsp);
    chk_irq(1'b0);
    grp(MODE_AVERAGE, 3'h0, 1'b0, 9'd2, 16'h0ffe);
    chk_irq(1'b0);
    rdchk(STATUS_OFF, 32'h0, "status no irq");
  endtask

  task automatic t_off_reserved;
    wr(CTRL_OFF, cv(MODE_OVERSAMPLE, 3'h0, 1'b0), rsp);
    repeat (3) @(posedge aclk);
    feed(9'd4);
    wr(CTRL_OFF, 32'h0, rsp);
    rdchk(CTRL_OFF, 32'h0, "ready after off");
    feed(9'd4);
    rdchk(CTRL_OFF, 32'h0, "ready while off");
    rdchk(RESULT_OFF, 32'h0000_1ffc, "result while off");
    for (int m = 1; m < 3; m++) begin
      wr(CTRL_OFF, cv(m[1:0], 3'h0, 1'b0), rsp);
      repeat (3) @(posedge aclk);
      feed(9'd4);
      rdchk(CTRL_OFF, cv(m[1:0], 3'h0, 1'b0), "reserved mode");
    end
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_oversample();
    t_average();
    t_restart();
    t_irq();
    t_off_reserved();
    end_sim;
  end
endmodule
